/* File: hdl/dtc_pin_sync.sv */
`timescale 1ns/10ps
// Three-stage synchroniser with edge detection on the last two stages.
module dtc_pin_sync
  import dtc_pkg::*;
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic pin_in,
  output logic      edge_pulse
);
  logic [2:0] sync_reg;
  logic [2:0] sync_next;

  always_comb begin
    sync_next = {sync_reg[1:0], pin_in};
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync_reg <= 3'h0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  // Only stages two and three take part in the edge decision.
  assign edge_pulse = sync_reg[1] ^ sync_reg[2];
endmodule

/* File: hdl/dtc_timer.sv */
`timescale 1ns/10ps
`include "dtc_consts.svh"
module dtc_timer
  import dtc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output dtc_byte_t       reg_rdata,
  input  wire logic       halt_mode,
  input  wire logic       capture_input_pin,
  output logic            timebase1_irq,
  output logic            timebase2_irq,
  output logic            capture_irq
);
  logic [4:0] prescale_reg;
  logic [4:0] prescale_next;
  dtc_byte_t  counter1_reg;
  dtc_byte_t  counter1_next;
  dtc_phase_t phase_reg;
  dtc_phase_t phase_next;
  dtc_byte_t  counter2_value_reg;
  dtc_byte_t  counter2_value_next;
  dtc_byte_t  counter2_reload_reg;
  dtc_byte_t  counter2_reload_next;
  dtc_byte_t  capture_value_reg;
  dtc_byte_t  capture_value_next;
  logic       started_reg;
  logic       started_next;
  logic       timebase1_flag;
  logic       timebase1_flag_next;
  logic       timebase1_irq_enable;
  logic       timebase1_irq_enable_next;
  logic       timebase2_flag;
  logic       timebase2_flag_next;
  logic       timebase2_irq_enable;
  logic       timebase2_irq_enable_next;
  logic       capture_flag;
  logic       capture_flag_next;
  logic       capture_irq_enable;
  logic       capture_irq_enable_next;
  logic       period_double_select;
  logic       period_double_select_next;
  dtc_byte_t  rdata_reg;
  dtc_byte_t  rdata_next;
  logic       tick;
  logic       cnt1_wrap;
  logic       tb1_event;
  logic       tb2_event;
  logic       pin_edge;
  logic       cap_event;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    hit = (addr == target);
  endfunction

  dtc_pin_sync u_sync (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .pin_in     (capture_input_pin),
    .edge_pulse (pin_edge)
  );

  assign tick      = (prescale_reg == `DTC_PRESCALE_LAST) && !halt_mode;
  assign cnt1_wrap = tick && (counter1_reg == `DTC_CNT1_LAST);
  // With period doubling, only every second wrap is an overflow event.
  assign tb1_event = cnt1_wrap && (!period_double_select || phase_reg == DTC_PHASE_SECOND);
  assign tb2_event = tick && started_reg && (counter2_value_reg == `DTC_CNT2_LAST);
  assign cap_event = pin_edge && !capture_flag;

  always_comb begin
    prescale_next = prescale_reg;
    counter1_next = counter1_reg;
    phase_next    = phase_reg;
    if (!halt_mode) begin
      prescale_next = prescale_reg + 5'h01;
    end
    if (tick) begin
      counter1_next = cnt1_wrap ? `DTC_BYTE_ZERO : counter1_reg + `DTC_BYTE_ONE;
    end
    if (cnt1_wrap) begin
      phase_next = (phase_reg == DTC_PHASE_FIRST) ? DTC_PHASE_SECOND : DTC_PHASE_FIRST;
    end
  end

  always_comb begin
    counter2_value_next  = counter2_value_reg;
    counter2_reload_next = counter2_reload_reg;
    started_next         = 1'b1;
    if (reg_write && hit(reg_addr, `DTC_ADDR_RELOAD)) begin
      counter2_reload_next = reg_wdata;
    end
    if (!started_reg) begin
      counter2_value_next = counter2_reload_reg;
    end else if (tb2_event) begin
      counter2_value_next = counter2_reload_reg;
    end else if (tick) begin
      counter2_value_next = counter2_value_reg + `DTC_BYTE_ONE;
    end
  end

  always_comb begin
    timebase1_flag_next       = timebase1_flag;
    timebase2_flag_next       = timebase2_flag;
    capture_flag_next         = capture_flag;
    capture_value_next        = capture_value_reg;
    timebase1_irq_enable_next = timebase1_irq_enable;
    timebase2_irq_enable_next = timebase2_irq_enable;
    capture_irq_enable_next   = capture_irq_enable;
    period_double_select_next = period_double_select;
    if (reg_write && hit(reg_addr, `DTC_ADDR_CSR1)) begin
      // The flag bits of this byte are ignored on write.
      capture_irq_enable_next   = reg_wdata[`DTC_CSR1_CAPIE];
      period_double_select_next = reg_wdata[`DTC_CSR1_PERDBL];
      timebase1_irq_enable_next = reg_wdata[`DTC_CSR1_TIMEBASE1_IRQ_ENABLE];
    end
    if (reg_write && hit(reg_addr, `DTC_ADDR_CSR2)) begin
      timebase2_irq_enable_next = reg_wdata[`DTC_CSR2_TIMEBASE2_IRQ_ENABLE];
    end
    // Clears come first so that a same-cycle hardware set wins.
    if (reg_read && hit(reg_addr, `DTC_ADDR_CSR1)) begin
      timebase1_flag_next = 1'b0;
    end
    if (reg_read && hit(reg_addr, `DTC_ADDR_CSR2)) begin
      timebase2_flag_next = 1'b0;
    end
    if (reg_read && hit(reg_addr, `DTC_ADDR_CAPTURE)) begin
      capture_flag_next = 1'b0;
    end
    if (tb1_event) begin
      timebase1_flag_next = 1'b1;
    end
    if (tb2_event) begin
      timebase2_flag_next = 1'b1;
    end
    if (cap_event) begin
      capture_flag_next  = 1'b1;
      capture_value_next = counter1_reg;
    end
  end

  always_comb begin
    rdata_next = `DTC_BYTE_ZERO;
    if (reg_read) begin
      case (reg_addr)
        `DTC_ADDR_CSR2: begin
          rdata_next[`DTC_CSR2_TIMEBASE2_IRQ_ENABLE] = timebase2_irq_enable;
          rdata_next[`DTC_CSR2_TIMEBASE2_FLAG]  = timebase2_flag;
        end
        `DTC_ADDR_RELOAD: begin
          rdata_next = counter2_reload_reg;
        end
        `DTC_ADDR_CNT2: begin
          rdata_next = counter2_value_reg;
        end
        `DTC_ADDR_CSR1: begin
          rdata_next[`DTC_CSR1_CAPIE]  = capture_irq_enable;
          rdata_next[`DTC_CSR1_CAPF]   = capture_flag;
          rdata_next[`DTC_CSR1_PERDBL] = period_double_select;
          rdata_next[`DTC_CSR1_TIMEBASE1_IRQ_ENABLE]  = timebase1_irq_enable;
          rdata_next[`DTC_CSR1_TIMEBASE1_FLAG]   = timebase1_flag;
        end
        `DTC_ADDR_CAPTURE: begin
          rdata_next = capture_value_reg;
        end
        default: begin
          rdata_next = `DTC_BYTE_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prescale_reg         <= 5'h00;
      counter1_reg         <= `DTC_BYTE_ZERO;
      phase_reg            <= DTC_PHASE_FIRST;
      counter2_value_reg   <= `DTC_BYTE_ZERO;
      counter2_reload_reg  <= `DTC_BYTE_ZERO;
      capture_value_reg    <= `DTC_BYTE_ZERO;
      started_reg          <= 1'b0;
      timebase1_flag       <= 1'b0;
      timebase2_flag       <= 1'b0;
      capture_flag         <= 1'b0;
      timebase1_irq_enable <= 1'b0;
      timebase2_irq_enable <= 1'b0;
      capture_irq_enable   <= 1'b0;
      period_double_select <= 1'b0;
      rdata_reg            <= `DTC_BYTE_ZERO;
    end else begin
      prescale_reg         <= prescale_next;
      counter1_reg         <= counter1_next;
      phase_reg            <= phase_next;
      counter2_value_reg   <= counter2_value_next;
      counter2_reload_reg  <= counter2_reload_next;
      capture_value_reg    <= capture_value_next;
      started_reg          <= started_next;
      timebase1_flag       <= timebase1_flag_next;
      timebase2_flag       <= timebase2_flag_next;
      capture_flag         <= capture_flag_next;
      timebase1_irq_enable <= timebase1_irq_enable_next;
      timebase2_irq_enable <= timebase2_irq_enable_next;
      capture_irq_enable   <= capture_irq_enable_next;
      period_double_select <= period_double_select_next;
      rdata_reg            <= rdata_next;
    end
  end

  assign reg_rdata     = rdata_reg;
  assign timebase1_irq = timebase1_flag && timebase1_irq_enable;
  assign timebase2_irq = timebase2_flag && timebase2_irq_enable;
  assign capture_irq   = capture_flag && capture_irq_enable;

  property p_tb1_set;
    @(posedge clk) disable iff (sys_rst) tb1_event |=> timebase1_flag;
  endproperty
  a_tb1_set: assert property (p_tb1_set) else $error("Timebase 1 flag not set on overflow.");

  property p_tb1_clear;
    @(posedge clk) disable iff (sys_rst)
      (reg_read && reg_addr == `DTC_ADDR_CSR1 && !tb1_event) |=> !timebase1_flag;
  endproperty
  a_tb1_clear: assert property (p_tb1_clear) else $error("Timebase 1 flag not cleared by read.");

  property p_cnt1_range;
    @(posedge clk) disable iff (sys_rst) counter1_reg <= `DTC_CNT1_LAST;
  endproperty
  a_cnt1_range: assert property (p_cnt1_range) else $error("Counter 1 beyond wrap value.");

  property p_capture_value;
    @(posedge clk) disable iff (sys_rst)
      (pin_edge && !capture_flag) |=> (capture_flag && capture_value_reg == $past(counter1_reg));
  endproperty
  a_capture_value: assert property (p_capture_value) else $error("Capture did not latch counter 1.");

  property p_capture_hold;
    @(posedge clk) disable iff (sys_rst) capture_flag |=> $stable(capture_value_reg);
  endproperty
  a_capture_hold: assert property (p_capture_hold) else $error("Capture taken while flag set.");

  property p_cap_clear;
    @(posedge clk) disable iff (sys_rst)
      (reg_read && reg_addr == `DTC_ADDR_CAPTURE && !pin_edge) |=> !capture_flag;
  endproperty
  a_cap_clear: assert property (p_cap_clear) else $error("Capture flag not cleared by read.");

  property p_cap_write;
    @(posedge clk) disable iff (sys_rst)
      (reg_write && !reg_read && !pin_edge) |=> (capture_flag == $past(capture_flag));
  endproperty
  a_cap_write: assert property (p_cap_write) else $error("Write changed the capture flag.");

  property p_reload;
    @(posedge clk) disable iff (sys_rst)
      tb2_event |=> (timebase2_flag && counter2_value_reg == $past(counter2_reload_reg));
  endproperty
  a_reload: assert property (p_reload) else $error("Counter 2 did not reload on overflow.");

  property p_halt;
    @(posedge clk) disable iff (sys_rst) (halt_mode && started_reg) |=> $stable(counter2_value_reg);
  endproperty
  a_halt: assert property (p_halt) else $error("Counter 2 moved in halt.");
endmodule

/* File: shared/dtc_consts.svh */
`ifndef DTC_CONSTS_SVH
`define DTC_CONSTS_SVH

// Register offsets on the plain register port.
`define DTC_ADDR_CSR2     8'h08
`define DTC_ADDR_RELOAD   8'h09
`define DTC_ADDR_CNT2     8'h0A
`define DTC_ADDR_CSR1     8'h0B
`define DTC_ADDR_CAPTURE  8'h0C

// Control/status 2 field positions.
`define DTC_CSR2_TIMEBASE2_FLAG     0
`define DTC_CSR2_TIMEBASE2_IRQ_ENABLE    1
// Control/status 1 field positions.
`define DTC_CSR1_TIMEBASE1_FLAG     3
`define DTC_CSR1_TIMEBASE1_IRQ_ENABLE    4
`define DTC_CSR1_PERDBL   5
`define DTC_CSR1_CAPF     6
`define DTC_CSR1_CAPIE    7

`define DTC_PRESCALE_LAST 5'h1F
`define DTC_CNT1_LAST     8'hF9
`define DTC_CNT2_LAST     8'hFF
`define DTC_BYTE_ZERO     8'h00
`define DTC_BYTE_ONE      8'h01

`endif

/* File: shared/dtc_pkg.sv */
package dtc_pkg;
  typedef logic [7:0] dtc_byte_t;
  typedef enum logic {DTC_PHASE_FIRST, DTC_PHASE_SECOND} dtc_phase_t;
endpackage

/* File: tb/tb_dtc_timer.sv */
`timescale 1ns/10ps
`include "dtc_consts.svh"
module tb_dtc_timer
  import dtc_pkg::*;
;
  typedef struct {logic [7:0] addr; dtc_byte_t wdata; dtc_byte_t exp;} dtc_row_t;
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_write = 1'b0;
  logic       reg_read = 1'b0;
  logic       halt_mode = 1'b0;
  logic       capture_input_pin = 1'b0;
  dtc_byte_t  reg_rdata;
  logic       timebase1_irq;
  logic       timebase2_irq;
  logic       capture_irq;
  int         err_total = 0;
  int         n_tests = 0;
  int         run_cyc = 0;
  int         cyc = 0;
  int         r1;
  dtc_byte_t  a;
  dtc_byte_t  b;
  dtc_row_t   rows [6];

  dtc_timer i_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .halt_mode(halt_mode),
    .capture_input_pin(capture_input_pin), .timebase1_irq(timebase1_irq),
    .timebase2_irq(timebase2_irq), .capture_irq(capture_irq));

  always #10 clk = ~clk;

  task automatic finish_test();
    $display("checks: %0d, mismatches: %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Run time excludes halted cycles, because both counters pause with the prescaler.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (!sys_rst && !halt_mode) begin
      run_cyc <= run_cyc + 1;
    end
    if (cyc == 40000) begin
      err_total++;
      finish_test();
    end
  end

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("Error %s: expected %h, seen %h", name, exp, got);
      err_total++;
    end
  endtask

  task automatic chk_rng(input string name, input dtc_byte_t lo, input dtc_byte_t hi, input dtc_byte_t got);
    n_tests++;
    if (((got >= lo) && (got <= hi)) !== 1'b1) begin
      $display("Error %s: expected %h..%h, seen %h", name, lo, hi, got);
      err_total++;
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] ad, output dtc_byte_t d);
    @(posedge clk);
    reg_addr <= ad;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic wait_run(input int n);
    while (run_cyc < n) @(posedge clk);
  endtask

  task automatic toggle_pin();
    @(posedge clk);
    capture_input_pin <= ~capture_input_pin;
  endtask

  initial begin
    rows[0] = '{`DTC_ADDR_RELOAD, 8'hA5, 8'hA5};
    rows[1] = '{`DTC_ADDR_CSR2, 8'h03, 8'h02};
    rows[2] = '{`DTC_ADDR_CSR1, 8'hFF, 8'hB0};
    rows[3] = '{`DTC_ADDR_CAPTURE, 8'h55, 8'h00};
    rows[4] = '{8'h20, 8'h77, 8'h00};
    rows[5] = '{`DTC_ADDR_CSR1, 8'h00, 8'h00};
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`DTC_ADDR_CAPTURE, a);
    rd(`DTC_ADDR_CSR1, a);
    chk("csr1 reset", 8'h00, a);
    rd(`DTC_ADDR_CSR2, a);
    chk("csr2 reset", 8'h00, a);
    for (int i = 0; i < 6; i++) begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, a);
      chk("row read back", rows[i].exp, a);
    end
    $display("test done: register rows");
    wr(`DTC_ADDR_RELOAD, 8'hF0);
    rd(`DTC_ADDR_CNT2, a);
    chk_rng("cnt2 start", 8'h00, 8'h08, a);
    repeat (30) @(posedge clk);
    rd(`DTC_ADDR_CNT2, b);
    chk("cnt2 step", a + 8'h01, b);
    @(posedge clk);
    halt_mode <= 1'b1;
    rd(`DTC_ADDR_CNT2, a);
    repeat (64) @(posedge clk);
    rd(`DTC_ADDR_CNT2, b);
    chk("cnt2 halted", a, b);
    @(posedge clk);
    halt_mode <= 1'b0;
    $display("test done: counter 2 step and halt");
    wr(`DTC_ADDR_CSR1, 8'h90);
    toggle_pin();
    r1 = run_cyc;
    repeat (8) @(posedge clk);
    chk("capture irq", 8'h01, {7'h00, capture_irq});
    wr(`DTC_ADDR_CSR1, 8'h90);
    rd(`DTC_ADDR_CSR1, a);
    chk("csr1 capture flag", 8'hD0, a);
    repeat (200) @(posedge clk);
    toggle_pin();
    repeat (10) @(posedge clk);
    rd(`DTC_ADDR_CAPTURE, a);
    chk_rng("capture value", 8'((r1 / 32) % 250), 8'((r1 / 32) % 250 + 1), a);
    chk("capture irq cleared", 8'h00, {7'h00, capture_irq});
    repeat (20) @(posedge clk);
    rd(`DTC_ADDR_CSR1, a);
    chk("no late capture", 8'h90, a);
    $display("test done: capture");
    wait_run(7800);
    rd(`DTC_ADDR_CSR1, a);
    chk("tb1 before overflow", 8'h90, a);
    wait_run(8300);
    chk("tb1 irq", 8'h01, {7'h00, timebase1_irq});
    rd(`DTC_ADDR_CSR1, a);
    chk("tb1 flag", 8'h98, a);
    chk("tb1 irq cleared", 8'h00, {7'h00, timebase1_irq});
    chk("tb2 irq", 8'h01, {7'h00, timebase2_irq});
    rd(`DTC_ADDR_CSR2, a);
    chk("tb2 flag", 8'h03, a);
    chk("tb2 irq cleared", 8'h00, {7'h00, timebase2_irq});
    rd(`DTC_ADDR_CNT2, a);
    chk_rng("cnt2 reloaded", 8'hF0, 8'hFF, a);
    wr(`DTC_ADDR_CSR1, 8'hB0);
    wait_run(8650);
    rd(`DTC_ADDR_CSR2, a);
    chk("tb2 short period early", 8'h02, a);
    wait_run(8900);
    chk("tb2 short period", 8'h01, {7'h00, timebase2_irq});
    $display("test done: timebase flags");
    wait_run(16300);
    rd(`DTC_ADDR_CSR1, a);
    wait_run(24300);
    rd(`DTC_ADDR_CSR1, b);
    chk("doubled period", 8'h01, {7'h00, a[3] ^ b[3]});
    $display("test done: period double");
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`DTC_ADDR_CNT2, a);
    chk("cnt2 after reset", 8'h00, a);
    rd(`DTC_ADDR_RELOAD, a);
    chk("reload after reset", 8'h00, a);
    rd(`DTC_ADDR_CAPTURE, a);
    chk("capture after reset", 8'h00, a);
    rd(`DTC_ADDR_CSR1, a);
    chk("csr1 after reset", 8'h00, a);
    rd(`DTC_ADDR_CSR2, a);
    chk("csr2 after reset", 8'h00, a);
    chk("irqs after reset", 8'h00, {5'h00, timebase1_irq, timebase2_irq, capture_irq});
    $display("test done: reset in mid-run");
    finish_test();
  end
endmodule
